// File: hw/acs_pkg.sv
// Constants and types for the conversion sequencer
package acs_pkg;
  localparam int ACS_CLK_HZ = 10_000_000;
  localparam int ACS_CLK_MHZ = ACS_CLK_HZ / 1_000_000;
  // Conversion state durations on the internal oscillator
  localparam int ACS_T60_1X_US = 133_000;
  localparam int ACS_T60_2X_US = 67_000;
  localparam int ACS_T50_1X_US = 160_000;
  localparam int ACS_T50_2X_US = 80_000;
  localparam int ACS_TBOTH_1X_US = 147_000;
  localparam int ACS_TBOTH_2X_US = 73_600;
  // Durations in external conversion clock cycles
  localparam int ACS_EXT_1X_CYC = 41036;
  localparam int ACS_EXT_2X_CYC = 20556;
  // External clock detection
  localparam int ACS_EXT_MIN_HZ = 10_000;
  localparam int ACS_DET_WIN_US = 200;
  localparam int ACS_DET_WIN_CYC = ACS_DET_WIN_US * ACS_CLK_MHZ;
  localparam int ACS_DET_MIN_EDGES = ACS_DET_WIN_US * ACS_EXT_MIN_HZ / 1_000_000;
  localparam int ACS_WIN_W = 11;
  localparam int ACS_CNT_W = 21;
  // Result word
  localparam int ACS_OUT_W = 24;
  localparam int ACS_SMP_W = 18;
  localparam int ACS_RB_W = 6;
  localparam int ACS_BYTE = 8;
  localparam logic [1:0] ACS_RES_BYTES = 2'h3;
  localparam logic [3:0] ACS_BYTE_BITS = 4'h8;
  localparam logic [3:0] ACS_BIT_RELOAD = 4'h9;
  // Slave addresses
  localparam logic [6:0] ACS_ADDR_LH = 7'h14;
  localparam logic [6:0] ACS_ADDR_LF = 7'h15;
  localparam logic [6:0] ACS_ADDR_FH = 7'h17;
  localparam logic [6:0] ACS_ADDR_FF = 7'h24;
  localparam logic [6:0] ACS_ADDR_HH = 7'h26;
  localparam logic [6:0] ACS_ADDR_HF = 7'h27;
  localparam logic [6:0] ACS_ADDR_GLOBAL = 7'h77;
  // Register map
  localparam int ACS_AXI_AW = 5;
  localparam logic [4:0] ACS_OFF_SAMPLE = 5'h00;
  localparam logic [4:0] ACS_OFF_STATUS = 5'h04;
  localparam logic [4:0] ACS_OFF_CONFIG = 5'h08;
  localparam logic [4:0] ACS_OFF_RESULT = 5'h0C;
  localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACS_RESP_DECERR = 2'h3;
  // Line rejection and gain codes
  localparam logic [1:0] ACS_REJ_BOTH = 2'h0;
  localparam logic [1:0] ACS_REJ_50 = 2'h1;
  localparam logic [1:0] ACS_REJ_60 = 2'h2;
  localparam logic [2:0] ACS_GAIN_1 = 3'h0;

  typedef enum logic [1:0] {
    ACS_SEQ_CONV = 2'b00,
    ACS_SEQ_SLEEP = 2'b01,
    ACS_SEQ_DIO = 2'b10
  } acs_seq_t;
  typedef enum logic [2:0] {
    ACS_BUS_IDLE = 3'b000,
    ACS_BUS_ADDR = 3'b001,
    ACS_BUS_ADDR_ACK = 3'b010,
    ACS_BUS_WR_BYTE = 3'b011,
    ACS_BUS_WR_ACK = 3'b100,
    ACS_BUS_RD_BYTE = 3'b101,
    ACS_BUS_RD_ACK = 3'b110,
    ACS_BUS_SKIP = 3'b111
  } acs_bus_t;
  typedef enum logic [1:0] {
    ACS_LVL_LOW = 2'b00,
    ACS_LVL_HIGH = 2'b01,
    ACS_LVL_FLOAT = 2'b10
  } acs_lvl_t;
  typedef struct packed {
    logic temp_sensor_select;
    logic [1:0] line_reject_select;
    logic double_rate_select;
    logic [2:0] gain_select_field;
    logic spare;
  } acs_cfg_t;
  localparam acs_cfg_t ACS_CFG_RESET = 8'h00;
endpackage

// File: hw/acs_seq_top.sv
// Conversion sequencer with two-wire slave and AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module acs_seq_top #(
  parameter int CYC_60_1X = acs_pkg::ACS_T60_1X_US * acs_pkg::ACS_CLK_MHZ,
  parameter int CYC_60_2X = acs_pkg::ACS_T60_2X_US * acs_pkg::ACS_CLK_MHZ,
  parameter int CYC_50_1X = acs_pkg::ACS_T50_1X_US * acs_pkg::ACS_CLK_MHZ,
  parameter int CYC_50_2X = acs_pkg::ACS_T50_2X_US * acs_pkg::ACS_CLK_MHZ,
  parameter int CYC_BOTH_1X = acs_pkg::ACS_TBOTH_1X_US * acs_pkg::ACS_CLK_MHZ,
  parameter int CYC_BOTH_2X = acs_pkg::ACS_TBOTH_2X_US * acs_pkg::ACS_CLK_MHZ,
  parameter int CYC_EXT_1X = acs_pkg::ACS_EXT_1X_CYC,
  parameter int CYC_EXT_2X = acs_pkg::ACS_EXT_2X_CYC
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite slave
  input logic awvalid,
  output logic awready,
  input logic [acs_pkg::ACS_AXI_AW-1:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [acs_pkg::ACS_AXI_AW-1:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Two-wire serial bus
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address pins, three-level sensed
  input acs_pkg::acs_lvl_t addr_hi_select_pin,
  input acs_pkg::acs_lvl_t addr_lo_or_ext_clock_pin,
  // Oscillator control
  output logic osc_en
);
  import acs_pkg::*;

  function automatic acs_cfg_t eff_cfg(acs_cfg_t c);
    acs_cfg_t e;
    e = c;
    if (c.temp_sensor_select) begin
      e.gain_select_field = ACS_GAIN_1;
      e.double_rate_select = 1'b0;
    end
    return e;
  endfunction

  function automatic logic [ACS_CNT_W-1:0] conv_len(acs_cfg_t c, logic ext);
    int n;
    if (ext) begin
      n = c.double_rate_select ? CYC_EXT_2X : CYC_EXT_1X;
    end else begin
      case (c.line_reject_select)
        ACS_REJ_60: n = c.double_rate_select ? CYC_60_2X : CYC_60_1X;
        ACS_REJ_50: n = c.double_rate_select ? CYC_50_2X : CYC_50_1X;
        default: n = c.double_rate_select ? CYC_BOTH_2X : CYC_BOTH_1X;
      endcase
    end
    return ACS_CNT_W'(n - 1);
  endfunction

  // Returns {valid, address}; unlisted pin pairs never match
  function automatic logic [7:0] addr_map(acs_lvl_t hi, acs_lvl_t lo);
    case ({hi, lo})
      {ACS_LVL_LOW, ACS_LVL_HIGH}: return {1'b1, ACS_ADDR_LH};
      {ACS_LVL_LOW, ACS_LVL_FLOAT}: return {1'b1, ACS_ADDR_LF};
      {ACS_LVL_FLOAT, ACS_LVL_HIGH}: return {1'b1, ACS_ADDR_FH};
      {ACS_LVL_FLOAT, ACS_LVL_FLOAT}: return {1'b1, ACS_ADDR_FF};
      {ACS_LVL_HIGH, ACS_LVL_HIGH}: return {1'b1, ACS_ADDR_HH};
      {ACS_LVL_HIGH, ACS_LVL_FLOAT}: return {1'b1, ACS_ADDR_HF};
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(logic [ACS_OUT_W-1:0] w, logic [1:0] i);
    case (i)
      2'h0: return w[ACS_OUT_W-1 -: ACS_BYTE];
      2'h1: return w[ACS_OUT_W-1-ACS_BYTE -: ACS_BYTE];
      default: return w[ACS_BYTE-1:0];
    endcase
  endfunction

  function automatic logic [ACS_AXI_AW-1:0] word_of(logic [ACS_AXI_AW-1:0] a);
    return {a[ACS_AXI_AW-1:2], 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // External clock detector

  logic lo_hi_q, lo_hi_d, ext_q, ext_d, ext_rise;
  logic [ACS_WIN_W-1:0] win_q, win_d;
  logic [1:0] edg_q, edg_d;

  assign ext_rise = lo_hi_d && !lo_hi_q;

  // Presence changes only at window ends, so the source never chatters
  always_comb begin
    lo_hi_d = (addr_lo_or_ext_clock_pin == ACS_LVL_HIGH);
    win_d = win_q + 1'b1;
    edg_d = edg_q;
    ext_d = ext_q;
    if (ext_rise && edg_q != 2'h3) begin
      edg_d = edg_q + 1'b1;
    end
    if (win_q == ACS_WIN_W'(ACS_DET_WIN_CYC - 1)) begin
      win_d = '0;
      edg_d = '0;
      ext_d = (edg_q >= 2'(ACS_DET_MIN_EDGES));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_hi_q <= 1'b0;
      win_q <= '0;
      edg_q <= '0;
      ext_q <= 1'b0;
    end else begin
      lo_hi_q <= lo_hi_d;
      win_q <= win_d;
      edg_q <= edg_d;
      ext_q <= ext_d;
    end
  end

  assign osc_en = !ext_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and two-wire slave

  acs_seq_t seq_q, seq_d;
  acs_bus_t bus_q, bus_d;
  acs_cfg_t cfg_q, cfg_d, cfg_e;
  acs_lvl_t lo_eff;
  logic scl_q, scl_d, sda_q, sda_d, rw_q, rw_d, oe_q, oe_d;
  logic scl_rise, scl_fall, start_c, stop_c, tick, hit, go;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, amap, nxt;
  logic [1:0] byte_q, byte_d;
  logic [ACS_CNT_W-1:0] cnt_q, cnt_d;
  logic [ACS_OUT_W-1:0] out_q, out_d;
  logic [ACS_SMP_W-1:0] smp_q, smp_d;

  assign lo_eff = ext_q ? ACS_LVL_HIGH : addr_lo_or_ext_clock_pin;
  assign amap = addr_map(addr_hi_select_pin, lo_eff);
  assign cfg_e = eff_cfg(cfg_q);
  assign scl_rise = scl_i && !scl_q;
  assign scl_fall = !scl_i && scl_q;
  assign start_c = scl_i && scl_q && sda_q && !sda_i;
  assign stop_c = scl_i && scl_q && !sda_q && sda_i;
  // Source switch mid-conversion only skews the count of that conversion
  assign tick = ext_q ? ext_rise : 1'b1;
  // Global address only for writes
  assign hit = (amap[7] && sh_q[7:1] == amap[6:0])
            || (sh_q[7:1] == ACS_ADDR_GLOBAL && !sh_q[0]);

  always_comb begin
    scl_d = scl_i;
    sda_d = sda_i;
    seq_d = seq_q;
    bus_d = bus_q;
    bit_d = bit_q;
    sh_d = sh_q;
    byte_d = byte_q;
    rw_d = rw_q;
    oe_d = oe_q;
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    out_d = out_q;
    go = 1'b0;
    nxt = rd_byte(out_q, (bus_q == ACS_BUS_ADDR_ACK) ? 2'h0 : byte_q);
    if (seq_q == ACS_SEQ_CONV) begin
      if (tick) begin
        cnt_d = cnt_q + 1'b1;
      end
      if (cnt_q >= conv_len(cfg_e, ext_q)) begin
        seq_d = ACS_SEQ_SLEEP;
        out_d = {smp_q, cfg_q[$bits(acs_cfg_t)-1 -: ACS_RB_W]};
      end
    end
    if (start_c) begin
      bus_d = ACS_BUS_ADDR;
      bit_d = '0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      bus_d = ACS_BUS_IDLE;
      oe_d = 1'b0;
      go = (seq_q == ACS_SEQ_DIO);
    end else begin
      case (bus_q)
        ACS_BUS_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_i};
            bit_d = bit_q + 1'b1;
          end
          if (scl_fall && bit_q == ACS_BYTE_BITS) begin
            if (hit && seq_q != ACS_SEQ_CONV) begin
              seq_d = ACS_SEQ_DIO;
              rw_d = sh_q[0];
              oe_d = 1'b1;
              bus_d = ACS_BUS_ADDR_ACK;
            end else begin
              bus_d = ACS_BUS_SKIP;
            end
          end
        end
        ACS_BUS_ADDR_ACK: begin
          if (scl_fall) begin
            bit_d = '0;
            byte_d = '0;
            if (rw_q) begin
              oe_d = !nxt[7];
              sh_d = {nxt[6:0], 1'b0};
              bus_d = ACS_BUS_RD_BYTE;
            end else begin
              oe_d = 1'b0;
              bus_d = ACS_BUS_WR_BYTE;
            end
          end
        end
        ACS_BUS_WR_BYTE: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_i};
            bit_d = bit_q + 1'b1;
          end
          if (scl_fall && bit_q == ACS_BYTE_BITS) begin
            oe_d = 1'b1;
            cfg_d = acs_cfg_t'(sh_q);
            bus_d = ACS_BUS_WR_ACK;
          end
        end
        ACS_BUS_WR_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            bit_d = '0;
            bus_d = ACS_BUS_WR_BYTE;
          end
        end
        ACS_BUS_RD_BYTE: begin
          if (scl_rise) begin
            bit_d = bit_q + 1'b1;
          end
          if (scl_fall) begin
            if (bit_q == ACS_BYTE_BITS) begin
              oe_d = 1'b0;
              byte_d = byte_q + 1'b1;
              bus_d = ACS_BUS_RD_ACK;
            end else begin
              oe_d = !sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
        end
        ACS_BUS_RD_ACK: begin
          if (scl_rise) begin
            if (byte_q == ACS_RES_BYTES) begin
              go = 1'b1;
              bus_d = ACS_BUS_SKIP;
            end else if (sda_i) begin
              bus_d = ACS_BUS_SKIP;
            end else begin
              bit_d = ACS_BIT_RELOAD;
            end
          end
          if (scl_fall && bit_q == ACS_BIT_RELOAD) begin
            oe_d = !nxt[7];
            sh_d = {nxt[6:0], 1'b0};
            bit_d = '0;
            bus_d = ACS_BUS_RD_BYTE;
          end
        end
        default: ;
      endcase
    end
    if (go) begin
      seq_d = ACS_SEQ_CONV;
      cnt_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      seq_q <= ACS_SEQ_CONV;
      bus_q <= ACS_BUS_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      byte_q <= '0;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      cfg_q <= ACS_CFG_RESET;
      cnt_q <= '0;
      out_q <= '0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      seq_q <= seq_d;
      bus_q <= bus_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [ACS_AXI_AW-1:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d, wm;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;

  assign awready = !aw_q && !bv_q;
  assign wready = !w_q && !bv_q;
  assign arready = !rv_q;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    smp_d = smp_q;
    wm = 32'(smp_q);
    if (awvalid && awready) begin
      aw_d = 1'b1;
      awa_d = awaddr;
    end
    if (wvalid && wready) begin
      w_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (bv_q && bready) begin
      bv_d = 1'b0;
    end
    // Response only after both halves, in either order
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = ACS_RESP_OKAY;
      case (word_of(awa_q))
        ACS_OFF_SAMPLE: begin
          for (int i = 0; i < 4; i++) begin
            if (ws_q[i]) begin
              wm[ACS_BYTE*i +: ACS_BYTE] = wd_q[ACS_BYTE*i +: ACS_BYTE];
            end
          end
          smp_d = wm[ACS_SMP_W-1:0];
        end
        ACS_OFF_STATUS, ACS_OFF_CONFIG, ACS_OFF_RESULT: ;
        default: br_d = ACS_RESP_DECERR;
      endcase
    end
    if (rv_q && rready) begin
      rv_d = 1'b0;
    end
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rr_d = ACS_RESP_OKAY;
      case (word_of(araddr))
        ACS_OFF_SAMPLE: rd_d = 32'(smp_q);
        ACS_OFF_STATUS: rd_d = 32'({amap, ext_q, seq_q});
        ACS_OFF_CONFIG: rd_d = 32'({cfg_e, cfg_q});
        ACS_OFF_RESULT: rd_d = 32'(out_q);
        default: begin
          rd_d = '0;
          rr_d = ACS_RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bv_q <= 1'b0;
      br_q <= ACS_RESP_OKAY;
      rv_q <= 1'b0;
      rd_q <= '0;
      rr_q <= ACS_RESP_OKAY;
      smp_q <= '0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      smp_q <= smp_d;
    end
  end

  assign bvalid = bv_q;
  assign bresp = br_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_nack_conv;
    bus_q == ACS_BUS_ADDR && scl_fall && bit_q == ACS_BYTE_BITS && !start_c && !stop_c
      && seq_q == ACS_SEQ_CONV |=> !sda_oe && bus_q == ACS_BUS_SKIP;
  endproperty
  a_nack_conv: assert property (p_nack_conv) else $error("ack given during conversion");

  property p_ack_dio;
    bus_q == ACS_BUS_ADDR_ACK |-> seq_q == ACS_SEQ_DIO && sda_oe;
  endproperty
  a_ack_dio: assert property (p_ack_dio) else $error("ack without data phase");

  property p_stop_conv;
    stop_c && seq_q == ACS_SEQ_DIO |=> seq_q == ACS_SEQ_CONV && cnt_q == '0;
  endproperty
  a_stop_conv: assert property (p_stop_conv) else $error("stop did not start conversion");

  property p_read3;
    bus_q == ACS_BUS_RD_ACK && scl_rise && byte_q == ACS_RES_BYTES && !stop_c && !start_c
      |=> seq_q == ACS_SEQ_CONV ##1 seq_q == ACS_SEQ_CONV;
  endproperty
  a_read3: assert property (p_read3) else $error("full read did not restart");

  sequence s_conv_end;
    seq_q == ACS_SEQ_CONV ##1 seq_q != ACS_SEQ_CONV;
  endsequence
  property p_conv_sleep;
    s_conv_end |-> seq_q == ACS_SEQ_SLEEP && out_q[ACS_OUT_W-1 -: ACS_SMP_W] == $past(smp_q);
  endproperty
  a_conv_sleep: assert property (p_conv_sleep) else $error("conversion end not sleep");

  property p_cfg_hold;
    !(bus_q == ACS_BUS_WR_BYTE && scl_fall && bit_q == ACS_BYTE_BITS) |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

  property p_temp;
    cfg_q.temp_sensor_select |-> cfg_e.gain_select_field == ACS_GAIN_1
      && !cfg_e.double_rate_select;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature mode not forced");

  property p_global;
    bus_q == ACS_BUS_ADDR && scl_fall && bit_q == ACS_BYTE_BITS && !start_c && !stop_c
      && sh_q == {ACS_ADDR_GLOBAL, 1'b0} && seq_q == ACS_SEQ_SLEEP
      |=> bus_q == ACS_BUS_ADDR_ACK && sda_oe;
  endproperty
  a_global: assert property (p_global) else $error("global write not acked");

  property p_ext_addr;
    ext_q |-> lo_eff == ACS_LVL_HIGH && !osc_en;
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("external clock address wrong");

  property p_ext_win;
    $changed(ext_q) |-> $past(win_q) == ACS_WIN_W'(ACS_DET_WIN_CYC - 1);
  endproperty
  a_ext_win: assert property (p_ext_win) else $error("clock switch off window end");

  property p_reset;
    // Own disable, or the default one would mask every attempt
    @(posedge aclk) disable iff (1'b0)
      !aresetn |=> seq_q == ACS_SEQ_CONV && cfg_q == ACS_CFG_RESET && !sda_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  c_read3: cover property (bus_q == ACS_BUS_RD_ACK && scl_rise && byte_q == ACS_RES_BYTES);
  c_nack: cover property (bus_q == ACS_BUS_ADDR && scl_fall && seq_q == ACS_SEQ_CONV);
  c_write: cover property (bus_q == ACS_BUS_WR_ACK ##[1:200] stop_c);
  c_ext: cover property ($rose(ext_q));
endmodule

// File: test/acs_i2c_master.sv
// Behavioural two-wire bus master driving the sequencer's slave port
`timescale 1ns/1ps
module acs_i2c_master (
  // Clock
  input wire logic aclk,
  // Bus wires, SDA resolved outside with pull-up
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Also serves as repeated start: SDA released while SCL low first
  task automatic start();
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b0;
    tick(1);
  endtask
  // Only issued after the ninth clock, with the bus released
  task automatic stop();
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b0;
    tick(3);
  endtask
  task automatic one_bit(input logic b, output logic s);
    sda_low <= !b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    s = sda;
    scl <= 1'b0;
    tick(1);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] q,
    output logic s9);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(d[i], s);
      q[i] = s;
    end
    one_bit(b9, s9);
  endtask
endmodule

// File: test/adc_conversion_sequencer_i2c_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_i2c_test;
  import acs_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_on = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00, cnt = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, got_v, smp, st = 32'h10;
  logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, osc_en, scl, m_low;
  logic [1:0] bresp, rresp;
  logic [7:0] cfg = 8'h00, lcfg = 8'h00;
  logic [3:0] strb = 4'hF;
  acs_lvl_t hi_p = ACS_LVL_LOW, lo_p = ACS_LVL_FLOAT, lo_w;
  // Low pin rises once only, so the clock detector never sees two edges in a window
  acs_lvl_t hi_t[6] = '{ACS_LVL_LOW, ACS_LVL_FLOAT, ACS_LVL_HIGH, ACS_LVL_LOW, ACS_LVL_FLOAT,
    ACS_LVL_HIGH};
  acs_lvl_t lo_t[6] = '{ACS_LVL_HIGH, ACS_LVL_HIGH, ACS_LVL_HIGH, ACS_LVL_FLOAT, ACS_LVL_FLOAT,
    ACS_LVL_FLOAT};
  logic [6:0] ad_t[6] = '{7'h14, 7'h17, 7'h26, 7'h15, 7'h24, 7'h27};
  int n_fail = 0, cmp_count = 0;
  string nm_q[$];
  logic [31:0] ex_q[$];
  event got_e;
  wire sda = !((sda_oe && !sda_o) || m_low);
  always #50 aclk = !aclk;
  always @(posedge aclk) cnt <= cnt + 5'h1;
  // Free-running external clock, one rising edge per 32 cycles
  assign lo_w = ext_on ? (cnt[4] ? ACS_LVL_HIGH : ACS_LVL_LOW) : lo_p;
  // Short conversions keep the run small; external lengths count external edges
  localparam int CONV_CYC = 200;
  localparam int EXT_CYC = 50;
  acs_seq_top #(.CYC_60_1X(CONV_CYC), .CYC_60_2X(CONV_CYC), .CYC_50_1X(CONV_CYC),
    .CYC_50_2X(CONV_CYC), .CYC_BOTH_1X(CONV_CYC), .CYC_BOTH_2X(CONV_CYC),
    .CYC_EXT_1X(EXT_CYC), .CYC_EXT_2X(EXT_CYC)) dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .addr_hi_select_pin(hi_p),
    .addr_lo_or_ext_clock_pin(lo_w), .osc_en(osc_en));
  acs_i2c_master m (.aclk(aclk), .sda(sda), .scl(scl), .sda_low(m_low));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("unexpected timeout");
    complete_run();
  endtask
  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic check(string nm, logic [31:0] v, logic [31:0] e);
    cmp_count++;
    if (v !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, v);
    end
  endtask
  // Results are compared in order against the oldest pending note
  always @(got_e) check(nm_q.pop_front(), got_v, ex_q.pop_front());
  task automatic note(string nm, logic [31:0] e);
    nm_q.push_back(nm);
    ex_q.push_back(e);
  endtask
  task automatic seen(logic [31:0] v);
    got_v = v;
    ->got_e;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(logic [4:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic axi_rd(logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rd_chk(string nm, logic [4:0] a, logic [31:0] m, logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    note(nm, e);
    axi_rd(a, d, r);
    seen(d & m);
  endtask
  task automatic wait_sleep();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 900; i++) begin
      axi_rd(ACS_OFF_STATUS, d, r);
      if (d[1:0] === 2'h1) return;
    end
    hang();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic addr_op(string nm, logic [6:0] a, logic rw, logic e);
    logic [7:0] q;
    logic s;
    note(nm, e);
    m.start();
    m.byte_io({a, rw}, 1'b1, q, s);
    seen(!s);
  endtask
  task automatic wr_cfg(logic [7:0] c);
    logic [7:0] q;
    logic s;
    note("wr_byte_ack", 1);
    m.byte_io(c, 1'b1, q, s);
    seen(!s);
    cfg = c;
  endtask
  task automatic read3(logic [6:0] a);
    logic [7:0] q;
    logic s;
    logic [23:0] e;
    // Readback holds the config of the conversion that made the result
    e = {smp[17:0], lcfg[7:2]};
    addr_op("rd_ack", a, 1'b1, 1'b1);
    for (int i = 2; i >= 0; i--) begin
      note("rd_byte", e[i*8+:8]);
      m.byte_io(8'hFF, i == 0, q, s);
      seen(q);
    end
    lcfg = cfg;
    m.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [6:0] ad;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    smp = xs() & 32'h3FFFF;
    axi_wr(ACS_OFF_SAMPLE, smp, r);
    // Low byte only: the upper sample bits must survive
    strb <= 4'h1;
    d = xs();
    axi_wr(ACS_OFF_SAMPLE, d, r);
    smp = {smp[31:8], d[7:0]};
    strb <= 4'hF;
    rd_chk("smp_strobe", ACS_OFF_SAMPLE, 32'hFFFFFFFF, smp);
    rd_chk("seq_reset", ACS_OFF_STATUS, 32'h3, 32'h0);
    rd_chk("cfg_reset", ACS_OFF_CONFIG, 32'hFFFF, 32'h0);
    addr_op("busy_nack", 7'h15, 1'b1, 1'b0);
    m.stop();
    wait_sleep();
    read3(7'h15);
    addr_op("reread_nack", 7'h15, 1'b1, 1'b0);
    m.stop();
    $display("test read done");
    for (int i = 0; i < 7; i++) begin
      if (i < 6) begin
        hi_p <= hi_t[i];
        lo_p <= lo_t[i];
      end
      ad = (i < 6) ? ad_t[i] : 7'h77;
      wait_sleep();
      addr_op("wr_ack", ad, 1'b0, 1'b1);
      wr_cfg(8'(xs()));
      m.stop();
      lcfg = cfg;
      rd_chk("seq_restart", ACS_OFF_STATUS, 32'h3, 32'h0);
      rd_chk("cfg", ACS_OFF_CONFIG, 32'hFFFF, {cfg[7] ? cfg & 8'hE1 : cfg, cfg});
    end
    $display("test address done");
    wait_sleep();
    addr_op("wr_ack", 7'h27, 1'b0, 1'b1);
    m.stop();
    rd_chk("seq_restart", ACS_OFF_STATUS, 32'h3, 32'h0);
    rd_chk("cfg_kept", ACS_OFF_CONFIG, 32'hFF, cfg);
    wait_sleep();
    addr_op("wr_ack", 7'h27, 1'b0, 1'b1);
    wr_cfg(8'(xs()));
    read3(7'h27);
    $display("test write read done");
    hi_p <= ACS_LVL_HIGH;
    ext_on <= 1'b1;
    for (int i = 0; i < 6000 && osc_en !== 1'b0; i++) @(posedge aclk);
    note("osc_off", 0);
    seen(osc_en);
    wait_sleep();
    addr_op("ext_ack", 7'h26, 1'b0, 1'b1);
    m.stop();
    ext_on <= 1'b0;
    for (int i = 0; i < 6000 && osc_en !== 1'b1; i++) @(posedge aclk);
    note("osc_on", 1);
    seen(osc_en);
    wait_sleep();
    $display("test clock done");
    axi_wr(ACS_OFF_STATUS, 32'hFFFFFFFF, r);
    note("ro_resp", ACS_RESP_OKAY);
    seen(r);
    note("unmapped", ACS_RESP_DECERR);
    axi_rd(5'h10, d, r);
    seen(r);
    // Let the checker take the last note before the verdict
    @(posedge aclk);
    $display("test registers done");
    complete_run();
  end
endmodule
